//--- design/tac_map.vh
// constants for the temperature alert qualifier and conversion control
// Notes on behaviour
// - alert only after required consecutive hot results, or cold ones in interrupt mode
// - settings bits four:three pick fault count
// - same count gates release and re-arm
// - settings bits six:five pick resolution
// - conversion 30 ms, doubling per bit
// - power-on reset restores all register defaults
// - reset values A000, 9600, 0000, 00
// - wait 2 ms before first conversion
// - result valid one period after start
// - bit one mode, bit two polarity
// - comparator alert holds, survives shutdown
// - interrupt alert cleared by read, shutdown
// - one-shot from shutdown, bit seven self-clears
`ifndef TAC_MAP_VH
`define TAC_MAP_VH
// clock period and documented times
`define TAC_CLK_NS      10
`define TAC_PWRUP_MS    2
`define TAC_CONV9_MS    30
// register byte addresses (printed index times four)
`define TAC_IDX_RESULT  0
`define TAC_IDX_CFG     1
`define TAC_IDX_RELEASE 2
`define TAC_IDX_LIMIT   3
`define TAC_ADDR_RESULT 8'h00
`define TAC_ADDR_CFG    8'h04
`define TAC_ADDR_RELEASE 8'h08
`define TAC_ADDR_LIMIT  8'h0C
`define TAC_ADDR_STAT   8'h10
`define TAC_ADDR_MASK   8'h14
// settings field positions
`define TAC_CFG_SHDN    0
`define TAC_CFG_INTM    1
`define TAC_CFG_POL     2
`define TAC_CFG_FQ_LO   3
`define TAC_CFG_FQ_HI   4
`define TAC_CFG_RES_LO  5
`define TAC_CFG_RES_HI  6
`define TAC_CFG_ONESHOT 7
// status bits
`define TAC_ST_DONE     0
`define TAC_ST_ALERT    1
// reset values and limit register write mask
`define TAC_RST_RESULT  16'h0000
`define TAC_RST_LIMIT   16'hA000
`define TAC_RST_RELEASE 16'h9600
`define TAC_RST_CFG     8'h00
`define TAC_LIMIT_BITS  16'hFF80
`endif

//--- design/tac_top.v
// temperature conversion control with fault-queued alert and axi4-lite registers
//
// Decided for this implementation: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`include "tac_map.vh"
module tac_top #(
    // 2 ms start-up delay in clock cycles
    parameter PWRUP_CYC = `TAC_PWRUP_MS * 1000000 / `TAC_CLK_NS,
    // 30 ms 9-bit conversion in clock cycles
    parameter CONV9_CYC = `TAC_CONV9_MS * 1000000 / `TAC_CLK_NS
) (
    input  wire        clk,
    input  wire        nrst,
    input  wire [31:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [31:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire [15:0] temp_code,
    output reg         alert_pin,
    output reg         irq
);
    // conversion states
    localparam [1:0] ST_PWRUP = 2'h0;
    localparam [1:0] ST_IDLE  = 2'h1;
    localparam [1:0] ST_CONV  = 2'h2;
    localparam [1:0] RESP_OK  = 2'h0;
    localparam [1:0] RESP_ERR = 2'h2;
    // fault count code to required run length
    function [2:0] fq_need;
        input [1:0] code;
        begin
            case (code)
                2'h0:    fq_need = 3'h1;
                2'h1:    fq_need = 3'h2;
                2'h2:    fq_need = 3'h4;
                2'h3:    fq_need = 3'h6;
                default: fq_need = 3'h1;
            endcase
        end
    endfunction
    // keep only the bits the chosen resolution produces
    function [15:0] res_mask;
        input [1:0] code;
        begin
            case (code)
                2'h0:    res_mask = 16'hFF80;
                2'h1:    res_mask = 16'hFFC0;
                2'h2:    res_mask = 16'hFFE0;
                2'h3:    res_mask = 16'hFFF0;
                default: res_mask = 16'hFF80;
            endcase
        end
    endfunction
    // byte-lane merge for the 16-bit registers
    function [15:0] lane16;
        input [15:0] old;
        input [31:0] wd;
        input [3:0]  st;
        begin
            lane16[7:0]  = st[0] ? wd[7:0]  : old[7:0];
            lane16[15:8] = st[1] ? wd[15:8] : old[15:8];
        end
    endfunction
    // saturating run counter step, capped at six
    function [2:0] run_step;
        input       cond;
        input [2:0] cnt;
        begin
            if (!cond)
                run_step = 3'h0;
            else if (cnt == 3'h6)
                run_step = 3'h6;
            else
                run_step = cnt + 3'h1;
        end
    endfunction
    reg  [15:0] result_reg;        // latest conversion result
    reg  [15:0] limit_reg;         // upper alert limit
    reg  [15:0] release_limit_reg; // hysteresis release limit
    reg  [7:0]  cfg;               // settings register
    reg  [1:0]  stat;              // sticky event bits
    reg  [1:0]  mask;              // interrupt enables
    reg  [1:0]  state;             // conversion state
    reg  [31:0] cnt;               // period counter
    reg         os_run;            // current conversion is one-shot
    reg  [2:0]  hi_run;            // consecutive hot results
    reg  [2:0]  lo_run;            // consecutive cold results
    reg         alert;             // qualified alert, active high
    reg         want_hi;           // interrupt mode waits for a hot run
    reg         aw_got;            // write address held
    reg         w_got;             // write data held
    reg  [7:0]  aw_hold;           // held write address
    reg  [31:0] wd_hold;           // held write data
    reg  [3:0]  ws_hold;           // held write strobes
    wire [31:0] conv_len = CONV9_CYC << cfg[`TAC_CFG_RES_HI:`TAC_CFG_RES_LO];
    wire        conv_end = (state == ST_CONV) && (cnt >= conv_len - 32'h1);
    wire        do_wr    = aw_got && w_got && !s_axi_bvalid;
    wire        do_rd    = s_axi_arvalid && s_axi_arready;
    wire        wr_cfg   = do_wr && (aw_hold == `TAC_ADDR_CFG) && ws_hold[0]
                           && (state != ST_PWRUP);
    wire        cfg_rd   = do_rd && (s_axi_araddr[7:0] <= `TAC_ADDR_LIMIT)
                           && (s_axi_araddr[31:8] == 24'h0);
    // one-shot accepted only when already in shutdown
    wire        os_go    = wr_cfg && cfg[`TAC_CFG_SHDN] && wd_hold[`TAC_CFG_SHDN]
                           && wd_hold[`TAC_CFG_ONESHOT];
    wire        shdn_in  = wr_cfg && !cfg[`TAC_CFG_SHDN] && wd_hold[`TAC_CFG_SHDN];
    // sample scaled to resolution, unused low bits forced to zero
    wire [15:0] sample   = temp_code
                           & res_mask(cfg[`TAC_CFG_RES_HI:`TAC_CFG_RES_LO]);
    wire        hot      = $signed(sample) > $signed(limit_reg);
    wire        cold     = $signed(sample) < $signed(release_limit_reg);
    wire [2:0]  need     = fq_need(cfg[`TAC_CFG_FQ_HI:`TAC_CFG_FQ_LO]);
    wire [2:0]  next_hi  = run_step(hot, hi_run);
    wire [2:0]  next_lo  = run_step(cold, lo_run);
    wire        hi_q     = conv_end && (next_hi >= need);
    wire        lo_q     = conv_end && (next_lo >= need);
    wire        intm     = cfg[`TAC_CFG_INTM];
    wire        alert_up = intm ? (hi_q && want_hi) || (lo_q && !want_hi)
                                : (hi_q && !alert);
    reg         next_alert;
    reg  [1:0]  ev;
    // axi write channel: address and data taken in either order
    always @(posedge clk) begin
        if (!nrst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OK;
            aw_got        <= 1'b0;
            w_got         <= 1'b0;
            aw_hold       <= 8'h00;
            wd_hold       <= 32'h0000_0000;
            ws_hold       <= 4'h0;
        end else begin
            // address beat
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got        <= 1'b1;
                s_axi_awready <= 1'b0;
                // out-of-window upper bits fold into an unmapped code
                aw_hold       <= (s_axi_awaddr[31:8] == 24'h0) ?
                                 s_axi_awaddr[7:0] : 8'hFF;
            end else if (!aw_got && !s_axi_bvalid) begin
                s_axi_awready <= 1'b1;
            end
            // data beat
            if (s_axi_wvalid && s_axi_wready) begin
                w_got        <= 1'b1;
                s_axi_wready <= 1'b0;
                wd_hold      <= s_axi_wdata;
                ws_hold      <= s_axi_wstrb;
            end else if (!w_got && !s_axi_bvalid) begin
                s_axi_wready <= 1'b1;
            end
            // response once both halves are in
            if (do_wr) begin
                aw_got       <= 1'b0;
                w_got        <= 1'b0;
                s_axi_bvalid <= 1'b1;
                case (aw_hold)
                    `TAC_ADDR_RESULT,
                    `TAC_ADDR_CFG,
                    `TAC_ADDR_RELEASE,
                    `TAC_ADDR_LIMIT,
                    `TAC_ADDR_STAT,
                    `TAC_ADDR_MASK: s_axi_bresp <= RESP_OK;
                    default:        s_axi_bresp <= RESP_ERR;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    // axi read channel: one read at a time, answer the cycle after address
    always @(posedge clk) begin
        if (!nrst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OK;
        end else if (do_rd) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= RESP_OK;
            s_axi_rdata   <= 32'h0000_0000;
            if (s_axi_araddr[31:8] != 24'h0) begin
                s_axi_rresp <= RESP_ERR;
            end else begin
                case (s_axi_araddr[7:0])
                    `TAC_ADDR_RESULT:  s_axi_rdata[15:0] <= result_reg;
                    `TAC_ADDR_CFG:     s_axi_rdata[7:0]  <= cfg;
                    `TAC_ADDR_RELEASE: s_axi_rdata[15:0] <= release_limit_reg;
                    `TAC_ADDR_LIMIT:   s_axi_rdata[15:0] <= limit_reg;
                    `TAC_ADDR_STAT:    s_axi_rdata[1:0]  <= stat;
                    `TAC_ADDR_MASK:    s_axi_rdata[1:0]  <= mask;
                    default:           s_axi_rresp       <= RESP_ERR;
                endcase
            end
        end else if (s_axi_rvalid) begin
            // hold the answer until the master takes it
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end else begin
            s_axi_arready <= 1'b1;
        end
    end
    // software registers; writes before start-up ends are dropped
    // so the defaults are what the first conversion sees
    always @(posedge clk) begin
        if (!nrst) begin
            limit_reg         <= `TAC_RST_LIMIT;
            release_limit_reg <= `TAC_RST_RELEASE;
            cfg               <= `TAC_RST_CFG;
            mask              <= 2'h0;
        end else begin
            if (do_wr && state != ST_PWRUP) begin
                case (aw_hold)
                    `TAC_ADDR_LIMIT:
                        limit_reg <= lane16(limit_reg, wd_hold, ws_hold)
                                     & `TAC_LIMIT_BITS;
                    `TAC_ADDR_RELEASE:
                        release_limit_reg <= lane16(release_limit_reg, wd_hold, ws_hold)
                                             & `TAC_LIMIT_BITS;
                    `TAC_ADDR_CFG:
                        if (ws_hold[0]) begin
                            cfg <= wd_hold[7:0];
                        end
                    `TAC_ADDR_MASK:
                        if (ws_hold[0]) begin
                            mask <= wd_hold[1:0];
                        end
                    default: ;
                endcase
            end
            // one-shot bit drops when its conversion ends; a write wins
            if (conv_end && os_run && !wr_cfg) begin
                cfg[`TAC_CFG_ONESHOT] <= 1'b0;
            end
        end
    end
    // conversion sequencer: start-up wait, shutdown idle, converting
    always @(posedge clk) begin
        if (!nrst) begin
            state      <= ST_PWRUP;
            cnt        <= 32'h0;
            os_run     <= 1'b0;
            result_reg <= `TAC_RST_RESULT;
        end else begin
            case (state)
                ST_PWRUP: begin
                    // settle time before the first conversion
                    if (cnt == PWRUP_CYC - 1) begin
                        cnt   <= 32'h0;
                        state <= ST_CONV;
                    end else begin
                        cnt <= cnt + 32'h1;
                    end
                end
                ST_IDLE: begin
                    cnt <= 32'h0;
                    if (os_go) begin
                        os_run <= 1'b1;
                        state  <= ST_CONV;
                    end else if (!cfg[`TAC_CFG_SHDN]) begin
                        state <= ST_CONV;
                    end
                end
                ST_CONV: begin
                    if (conv_end) begin
                        // result only ever updated by a full period
                        result_reg <= sample;
                        cnt        <= 32'h0;
                        os_run     <= 1'b0;
                        if (cfg[`TAC_CFG_SHDN]) begin
                            state <= ST_IDLE;
                        end
                    end else if (shdn_in && !os_run) begin
                        // shutdown stops sampling, partial result dropped
                        cnt   <= 32'h0;
                        state <= ST_IDLE;
                    end else begin
                        cnt <= cnt + 32'h1;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                    cnt   <= 32'h0;
                end
            endcase
        end
    end

    // next alert level; a new event beats a clearing read
    always @* begin
        next_alert = alert;
        if (alert_up) begin
            next_alert = 1'b1;
        end else if (!intm && lo_q) begin
            next_alert = 1'b0;
        end else if (intm && (cfg_rd || shdn_in)) begin
            next_alert = 1'b0;
        end
    end

    // fault queue runs and alert state
    always @(posedge clk) begin
        if (!nrst) begin
            hi_run  <= 3'h0;
            lo_run  <= 3'h0;
            alert   <= 1'b0;
            want_hi <= 1'b1;
        end else begin
            if (conv_end) begin
                hi_run <= next_hi;
                lo_run <= next_lo;
            end
            alert <= next_alert;
            // interrupt mode alternates between hot and cold runs
            if (intm && alert_up) begin
                want_hi <= !want_hi;
            end else if (!intm) begin
                want_hi <= !alert;
            end
        end
    end

    // alert pin polarity; comparator level survives shutdown since
    // nothing clears it without a conversion
    always @(posedge clk) begin
        if (!nrst) begin
            alert_pin <= 1'b1;
        end else begin
            alert_pin <= cfg[`TAC_CFG_POL] ? alert : !alert;
        end
    end

    // sticky events, write one to clear, set wins over clear
    always @* begin
        ev                = 2'h0;
        ev[`TAC_ST_DONE]  = conv_end;
        ev[`TAC_ST_ALERT] = alert_up;
    end

    always @(posedge clk) begin
        if (!nrst) begin
            stat <= 2'h0;
            irq  <= 1'b0;
        end else begin
            if (do_wr && aw_hold == `TAC_ADDR_STAT && ws_hold[0]) begin
                stat <= (stat & ~wd_hold[1:0]) | ev;
            end else begin
                stat <= stat | ev;
            end
            irq <= |(stat & mask);
        end
    end

endmodule

//--- test/tac_chk.sv
// assertion checker bound to the temperature alert block
`timescale 1ns/1ps
module tac_chk #(
    parameter PWRUP_CYC = 20,
    parameter CONV9_CYC = 40
) (
    input wire        clk,
    input wire        nrst,
    input wire [31:0] s_axi_araddr,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0]  s_axi_rresp,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire        alert_pin,
    input wire        irq
);
    logic [7:0]  ra;   // address of the read in flight
    logic [19:0] cyc;  // cycles since reset release, saturating
    wire         ar_hs = s_axi_arvalid && s_axi_arready;
    // remember read address and time since release
    always @(posedge clk) begin
        if (!nrst) begin
            ra  <= 8'h00;
            cyc <= 20'h00000;
        end else begin
            if (ar_hs) begin
                ra <= s_axi_araddr[7:0];
            end
            if (cyc != 20'hFFFFF) begin
                cyc <= cyc + 20'h00001;
            end
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // reset must win even while held, so no disable here
    rst_vals_a: assert property (disable iff (1'b0) !nrst |=>
        !s_axi_bvalid && !s_axi_rvalid && alert_pin && !irq) else $error("reset state wrong");
    rd_lat_a: assert property (ar_hs |=> s_axi_rvalid) else $error("read answer late");
    rd_once_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer repeated");
    wr_once_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer repeated");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("second read taken");
    unmapped_rd_a: assert property (ar_hs && s_axi_araddr[7:0] > 8'h14 |=> s_axi_rresp == 2'b10)
        else $error("unmapped read not refused");
    res_lsb_a: assert property (s_axi_rvalid && ra == 8'h00 |->
        s_axi_rdata[3:0] == 4'h0 && s_axi_rdata[31:16] == 16'h0000) else $error("result bits");
    lim_lsb_a: assert property (s_axi_rvalid && ra == 8'h0C |->
        s_axi_rdata[6:0] == 7'h00 && s_axi_rdata[31:16] == 16'h0000) else $error("limit bits");
    // nothing may alert before start-up wait plus one conversion
    quiet_start_a: assert property (cyc < PWRUP_CYC + CONV9_CYC |-> alert_pin && !irq)
        else $error("alert during start-up");
    cover property (ar_hs && s_axi_araddr[7:0] == 8'h20);
    cover property ($fell(alert_pin));
    cover property ($rose(irq));
endmodule
bind tac_top tac_chk #(.PWRUP_CYC(PWRUP_CYC), .CONV9_CYC(CONV9_CYC)) chk (
    .clk(clk), .nrst(nrst), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .alert_pin(alert_pin), .irq(irq));

//--- test/tac_host.sv
// register bus master model standing on the far side of the block
`timescale 1ns/1ps
module tac_host (
    input  wire         clk,
    output logic [31:0] s_axi_awaddr,
    output logic        s_axi_awvalid,
    input  wire         s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0]  s_axi_wstrb,
    output logic        s_axi_wvalid,
    input  wire         s_axi_wready,
    input  wire  [1:0]  s_axi_bresp,
    input  wire         s_axi_bvalid,
    output logic        s_axi_bready,
    output logic [31:0] s_axi_araddr,
    output logic        s_axi_arvalid,
    input  wire         s_axi_arready,
    input  wire  [31:0] s_axi_rdata,
    input  wire  [1:0]  s_axi_rresp,
    input  wire         s_axi_rvalid,
    output logic        s_axi_rready
);
    // idle bus; response readies stay up so answers never stall
    initial begin
        s_axi_awaddr  = 32'h00000000;
        s_axi_awvalid = 1'b0;
        s_axi_wdata   = 32'h00000000;
        s_axi_wstrb   = 4'hF;
        s_axi_wvalid  = 1'b0;
        s_axi_bready  = 1'b1;
        s_axi_araddr  = 32'h00000000;
        s_axi_arvalid = 1'b0;
        s_axi_rready  = 1'b1;
    end
    // one write: address and data offered together, each dropped when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok  = 1'b0;
        @(posedge clk);
        s_axi_awaddr  <= {24'h000000, a};
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge clk);
            if (s_axi_awready === 1'b1 && !aw_ok) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wready === 1'b1 && !w_ok) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge clk); while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
    endtask
    // one read: address held until taken, data taken with rvalid
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        s_axi_araddr  <= {24'h000000, a};
        s_axi_arvalid <= 1'b1;
        do @(posedge clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask
endmodule

//--- test/testbench.sv
// self-checking bench for the temperature alert block
`timescale 1ns/1ps
`include "tac_map.vh"
module testbench;
    localparam int          PW   = 20;       // shortened start-up wait
    localparam int          CV   = 40;       // shortened 9-bit conversion
    localparam logic [15:0] HOT  = 16'h5100; // 81 degrees
    localparam logic [15:0] COLD = 16'h12F8; // about 19 degrees
    logic        clk, nrst, irq, alert_pin;
    logic [15:0] temp_code;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [31:0] dat;
    int          n_fail = 0, n_checks = 0, cyc = 0, t0, tr;
    int          nq[4] = '{1, 2, 4, 6};  // conversions needed per fault code
    tac_top #(.PWRUP_CYC(PW), .CONV9_CYC(CV)) uut (.*);
    tac_host host (.*);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // watchdog: a hang counts as a mismatch
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            summarize();
        end
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // alert pin trails its cause by two cycles, so let it settle first
    task automatic chk_alert(input logic e);
        repeat (2) @(posedge clk);
        chk("alert_pin", {31'h0, e}, {31'h0, alert_pin});
    endtask
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        host.wr(a, d, rsp);
        chk("bresp", 32'h0, {30'h0, rsp});
    endtask
    task automatic rreg(input logic [7:0] a, input logic [31:0] e);
        host.rd(a, dat, rsp);
        chk("rresp", 32'h0, {30'h0, rsp});
        chk("rdata", e, dat);
    endtask
    // wait for a conversion-done interrupt, note its time, then clear it
    task automatic next_done();
        while (irq !== 1'b1) @(posedge clk);
        tr = cyc;
        wreg(`TAC_ADDR_STAT, 32'h1);
        while (irq !== 1'b0) @(posedge clk);
    endtask
    initial begin
        nrst = 1'b0;
        temp_code = COLD;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        wreg(`TAC_ADDR_CFG, 32'h18);
        rreg(`TAC_ADDR_CFG, 32'h0);
        rreg(`TAC_ADDR_RESULT, 32'h0);
        rreg(`TAC_ADDR_LIMIT, 32'hA000);
        rreg(`TAC_ADDR_RELEASE, 32'h9600);
        host.rd(8'h20, dat, rsp);
        chk("rresp", 32'h2, {30'h0, rsp});
        host.wr(8'h20, 32'h1, rsp);
        chk("bresp", 32'h2, {30'h0, rsp});
        wreg(`TAC_ADDR_LIMIT, 32'h507F);
        rreg(`TAC_ADDR_LIMIT, 32'h5000);
        wreg(`TAC_ADDR_RELEASE, 32'h4B00);
        wreg(`TAC_ADDR_MASK, 32'h1);
        $display("test defaults done");
        // period measured over a whole conversion at each resolution
        for (int rs = 0; rs < 4; rs++) begin
            wreg(`TAC_ADDR_CFG, 32'(rs << 5));
            next_done();
            next_done();
            t0 = tr;
            next_done();
            chk("period", 32'(CV << rs), 32'(tr - t0));
            rreg(`TAC_ADDR_RESULT, 32'(COLD & ~(16'h007F >> rs)));
        end
        $display("test resolution done");
        // hot run then cold run of exactly the queued length
        for (int c = 0; c < 4; c++) begin
            next_done();
            temp_code <= HOT;
            wreg(`TAC_ADDR_CFG, 32'(c << 3));
            for (int k = 1; k <= nq[c]; k++) begin
                next_done();
                chk_alert(k != nq[c]);
            end
            if (c == 0) begin
                wreg(`TAC_ADDR_CFG, 32'h04);
                chk_alert(1'b1);
                wreg(`TAC_ADDR_CFG, 32'h00);
            end
            temp_code <= COLD;
            for (int k = 1; k <= nq[c]; k++) begin
                next_done();
                chk_alert(k == nq[c]);
            end
        end
        $display("test fault queue done");
        temp_code <= HOT;
        wreg(`TAC_ADDR_CFG, 32'h00);
        next_done();
        chk_alert(1'b0);
        wreg(`TAC_ADDR_CFG, 32'h01);
        chk_alert(1'b0);
        temp_code <= 16'h5A40;
        repeat (3 * CV) @(posedge clk);
        rreg(`TAC_ADDR_RESULT, 32'h5100);
        wreg(`TAC_ADDR_CFG, 32'h81);
        next_done();
        rreg(`TAC_ADDR_CFG, 32'h01);
        rreg(`TAC_ADDR_RESULT, 32'h5A00);
        $display("test one-shot done");
        temp_code <= COLD;
        wreg(`TAC_ADDR_CFG, 32'h02);
        next_done();
        next_done();
        rreg(`TAC_ADDR_RESULT, 32'h1280);
        chk_alert(1'b1);
        temp_code <= HOT;
        next_done();
        chk_alert(1'b0);
        rreg(`TAC_ADDR_RESULT, 32'h5100);
        chk_alert(1'b1);
        next_done();
        chk_alert(1'b1);
        temp_code <= COLD;
        next_done();
        chk_alert(1'b0);
        rreg(`TAC_ADDR_RELEASE, 32'h4B00);
        chk_alert(1'b1);
        temp_code <= HOT;
        next_done();
        chk_alert(1'b0);
        wreg(`TAC_ADDR_CFG, 32'h03);
        chk_alert(1'b1);
        $display("test interrupt mode done");
        // alert-raised status only reaches irq once unmasked
        rreg(`TAC_ADDR_STAT, 32'h2);
        chk("irq", 32'h0, {31'h0, irq});
        wreg(`TAC_ADDR_MASK, 32'h2);
        repeat (2) @(posedge clk);
        chk("irq", 32'h1, {31'h0, irq});
        wreg(`TAC_ADDR_STAT, 32'h2);
        repeat (2) @(posedge clk);
        chk("irq", 32'h0, {31'h0, irq});
        $display("test irq done");
        nrst <= 1'b0;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        rreg(`TAC_ADDR_LIMIT, 32'hA000);
        rreg(`TAC_ADDR_CFG, 32'h0);
        chk_alert(1'b1);
        $display("test second reset done");
        summarize();
    end
endmodule
